// ### verilog/pwr_seq_map.svh
// timing and field constants for the power and reset sequencer
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
`define CLK_PERIOD_NS 25
`define ACTIVATION_TIME_S 50
`define HARD_RESET_MIN_S 1
`define NS_PER_S 1000000000
`define ACTIVATION_CYCLES ((`ACTIVATION_TIME_S * 64'd`NS_PER_S + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HARD_RESET_CYCLES ((`HARD_RESET_MIN_S * 64'd`NS_PER_S + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FINALIZE_CYCLES 64
`define BOOT_CYCLES 1000
`define BOOT_OK_RESET 1'b0
`define SHDN_IND_EN_RESET 1'b0
`define FAST_SHDN_EN_RESET 1'b0
`endif

// ### verilog/pwr_seq_pkg.sv
// types shared by both ends of the power and reset sequencer
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        dev_off, dev_boot, dev_init, dev_active, dev_final, dev_halted
    } dev_state_e;
    typedef enum logic [2:0] {
        host_idle, host_wait_ready, host_run, host_drain, host_reset_hold, host_stopped
    } host_state_e;
endpackage

// ### verilog/pwr_seq_if.sv
// link between the module end and the host end
`timescale 1ns/10ps
interface pwr_seq_if;
    logic power_on_req;
    logic hard_restart_line_oe_n;
    logic hard_restart_line;
    logic trigger_line;
    logic indicator_line;
    logic reference_voltage_output;
    assign hard_restart_line = hard_restart_line_oe_n ? 1'b1 : 1'b0;
    modport dev (
        input power_on_req, hard_restart_line, trigger_line,
        output indicator_line, reference_voltage_output
    );
    modport host (
        output power_on_req, hard_restart_line_oe_n, trigger_line,
        input indicator_line, reference_voltage_output
    );
endinterface

// ### verilog/pwr_seq_timer.sv
// loadable down-counter with terminal flag
`timescale 1ns/10ps
module pwr_seq_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    output logic done_out
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (load_in) begin
            cnt_nxt = count_in;
            done_nxt = 1'b0;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            done_nxt = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end
    assign done_out = done_r;
endmodule // pwr_seq_timer

// ### verilog/pwr_seq_host.sv
// host-side sequencer driving power, restart and trigger lines
`timescale 1ns/10ps
`include "pwr_seq_map.svh"
module pwr_seq_host #(
    parameter int unsigned ACTIVATION_CYCLES = 32'(`ACTIVATION_CYCLES),
    parameter int unsigned HARD_RESET_CYCLES = 32'(`HARD_RESET_CYCLES + 1)
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    pwr_seq_if.host link,
    input wire logic power_up_in,
    input wire logic power_down_in,
    input wire logic fast_down_in,
    input wire logic emergency_reset_in,
    output logic ready_out,
    output logic stopped_out
);
    pwr_seq_pkg::host_state_e st_r, st_nxt;
    logic ind_s1_r, ind_s2_r, ref_s1_r, ref_s2_r;
    logic pwr_r, pwr_nxt, rst_oe_n_r, rst_oe_n_nxt, trig_r, trig_nxt;
    logic ready_r, ready_nxt, stopped_r, stopped_nxt;
    logic load, done;
    logic [31:0] load_val;
    pwr_seq_timer #(.WIDTH(32)) u_timer (
        .clock_in(clock_in), .resetn_in(resetn_in), .load_in(load),
        .count_in(load_val), .done_out(done)
    );
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ind_s1_r <= 1'b0;
            ind_s2_r <= 1'b0;
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
        end else begin
            ind_s1_r <= link.indicator_line;
            ind_s2_r <= ind_s1_r;
            ref_s1_r <= link.reference_voltage_output;
            ref_s2_r <= ref_s1_r;
        end
    end
    always_comb begin
        st_nxt = st_r;
        pwr_nxt = pwr_r;
        rst_oe_n_nxt = rst_oe_n_r;
        trig_nxt = trig_r;
        ready_nxt = ready_r;
        stopped_nxt = stopped_r;
        load = 1'b0;
        load_val = ACTIVATION_CYCLES;
        if (emergency_reset_in && st_r != pwr_seq_pkg::host_reset_hold) begin
            st_nxt = pwr_seq_pkg::host_reset_hold;
            rst_oe_n_nxt = 1'b0;
            ready_nxt = 1'b0;
            load = 1'b1;
            load_val = HARD_RESET_CYCLES;
        end else begin
            unique case (st_r)
                pwr_seq_pkg::host_idle: begin
                    if (power_up_in) begin
                        pwr_nxt = 1'b1;
                        rst_oe_n_nxt = 1'b1;
                        trig_nxt = 1'b1;
                        stopped_nxt = 1'b0;
                        load = 1'b1;
                        st_nxt = pwr_seq_pkg::host_wait_ready;
                    end
                end
                pwr_seq_pkg::host_wait_ready: begin
                    if (done) begin
                        ready_nxt = 1'b1;
                        st_nxt = pwr_seq_pkg::host_run;
                    end
                end
                pwr_seq_pkg::host_run: begin
                    if (power_down_in) begin
                        pwr_nxt = 1'b0;
                        ready_nxt = 1'b0;
                        st_nxt = pwr_seq_pkg::host_drain;
                    end else if (fast_down_in) begin
                        trig_nxt = 1'b0;
                        ready_nxt = 1'b0;
                        st_nxt = pwr_seq_pkg::host_drain;
                    end
                end
                pwr_seq_pkg::host_drain: begin
                    if (!ref_s2_r) begin
                        pwr_nxt = 1'b0;
                        trig_nxt = 1'b0;
                        stopped_nxt = 1'b1;
                        st_nxt = pwr_seq_pkg::host_stopped;
                    end
                end
                pwr_seq_pkg::host_reset_hold: begin
                    if (done) begin
                        rst_oe_n_nxt = 1'b1;
                        load = 1'b1;
                        st_nxt = pwr_seq_pkg::host_wait_ready;
                    end
                end
                pwr_seq_pkg::host_stopped: begin
                    if (power_up_in) begin
                        st_nxt = pwr_seq_pkg::host_idle;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= pwr_seq_pkg::host_idle;
            pwr_r <= 1'b0;
            rst_oe_n_r <= 1'b1;
            trig_r <= 1'b0;
            ready_r <= 1'b0;
            stopped_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pwr_r <= pwr_nxt;
            rst_oe_n_r <= rst_oe_n_nxt;
            trig_r <= trig_nxt;
            ready_r <= ready_nxt;
            stopped_r <= stopped_nxt;
        end
    end
    assign link.power_on_req = pwr_r;
    assign link.hard_restart_line_oe_n = rst_oe_n_r;
    assign link.trigger_line = trig_r;
    assign ready_out = ready_r;
    assign stopped_out = stopped_r;
endmodule // pwr_seq_host

// ### verilog/pwr_seq_dev.sv
// module-side power, shutdown and restart sequencer
`timescale 1ns/10ps
`include "pwr_seq_map.svh"
// Functional notes
// - host raises power line to run
// - restart line must not be low
// - active no sooner than 50 s
// - host waits through initialization
// - indicator rises when boot completes
// - indicator meaningful only once enabled
// - host keeps lines low while off
// - power line low starts graceful shutdown
// - reference output drops when shutdown ends
// - trigger line active only when configured
// - trigger falling edge starts fast shutdown
// - fast shutdown disabled after reset
// - indicator disabled by default
// - host holds power line after fast shutdown; the host drops it once the reference output falls
// - restart only by repower or reset; module reboots after a pause unless fast halt with indicator
// - restart line low over 1 s restarts
// - hard reset only for emergencies
// - restart line open-drain only; the link drives it to 1 when hard_restart_line_oe_n is high, not released
// - reference output on while module on
module pwr_seq_dev #(
    parameter int unsigned ACTIVATION_CYCLES = 32'(`ACTIVATION_CYCLES),
    parameter int unsigned HARD_RESET_CYCLES = 32'(`HARD_RESET_CYCLES),
    parameter int unsigned FINALIZE_CYCLES = `FINALIZE_CYCLES
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    pwr_seq_if.dev link,
    input wire logic indicator_enable_in,
    input wire logic fast_shutdown_enable_in,
    output logic active_out,
    output logic finalizing_out
);
    pwr_seq_pkg::dev_state_e st_r;
    pwr_seq_pkg::dev_state_e st_nxt;
    logic pwr_s1_r;
    logic pwr_s2_r;
    logic rst_s1_r;
    logic rst_s2_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_d_r;
    logic ind_en_r;
    logic ind_en_nxt;
    logic fs_en_r;
    logic fs_en_nxt;
    logic boot_ok_r;
    logic boot_ok_nxt;
    logic ref_r;
    logic ref_nxt;
    logic ind_r;
    logic ind_nxt;
    logic act_r;
    logic act_nxt;
    logic fin_r;
    logic fin_nxt;
    logic fast_halt_r;
    logic fast_halt_nxt;
    logic [31:0] hold_r;
    logic [31:0] hold_nxt;
    logic load;
    logic done;
    logic trig_fall;
    logic hard_reset;
    logic [31:0] load_val;
    pwr_seq_timer #(.WIDTH(32)) u_timer (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .load_in(load),
        .count_in(load_val),
        .done_out(done)
    );
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_s1_r <= 1'b0;
            pwr_s2_r <= 1'b0;
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            pwr_s1_r <= link.power_on_req;
            pwr_s2_r <= pwr_s1_r;
            rst_s1_r <= link.hard_restart_line;
            rst_s2_r <= rst_s1_r;
            trig_s1_r <= link.trigger_line;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end
    assign trig_fall = fs_en_r && trig_d_r && !trig_s2_r;
    // low hold counter; restart fires on release after long hold
    assign hard_reset = rst_s2_r && (hold_r > HARD_RESET_CYCLES);
    always_comb begin
        hold_nxt = rst_s2_r ? 32'h0 : ((hold_r == 32'hFFFFFFFF) ? hold_r : hold_r + 32'h1);
    end
    always_comb begin
        st_nxt = st_r;
        ind_en_nxt = indicator_enable_in;
        fs_en_nxt = fast_shutdown_enable_in;
        boot_ok_nxt = boot_ok_r;
        ref_nxt = ref_r;
        act_nxt = act_r;
        fin_nxt = fin_r;
        fast_halt_nxt = fast_halt_r;
        load = 1'b0;
        load_val = ACTIVATION_CYCLES;
        if (hard_reset) begin
            st_nxt = pwr_seq_pkg::dev_off;
            ref_nxt = 1'b0;
            act_nxt = 1'b0;
            fin_nxt = 1'b0;
            boot_ok_nxt = 1'b0;
            fast_halt_nxt = 1'b0;
        end else begin
            unique case (st_r)
                pwr_seq_pkg::dev_off: begin
                    if (pwr_s2_r && rst_s2_r) begin
                        ref_nxt = 1'b1;
                        load = 1'b1;
                        st_nxt = pwr_seq_pkg::dev_init;
                    end
                end
                pwr_seq_pkg::dev_boot, pwr_seq_pkg::dev_init: begin
                    if (!pwr_s2_r || trig_fall) begin
                        load = 1'b1;
                        load_val = FINALIZE_CYCLES;
                        fin_nxt = 1'b1;
                        fast_halt_nxt = trig_fall;
                        st_nxt = pwr_seq_pkg::dev_final;
                    end else if (done) begin
                        boot_ok_nxt = 1'b1;
                        act_nxt = 1'b1;
                        st_nxt = pwr_seq_pkg::dev_active;
                    end
                end
                pwr_seq_pkg::dev_active: begin
                    if (!pwr_s2_r || trig_fall) begin
                        load = 1'b1;
                        load_val = FINALIZE_CYCLES;
                        act_nxt = 1'b0;
                        fin_nxt = 1'b1;
                        fast_halt_nxt = trig_fall;
                        st_nxt = pwr_seq_pkg::dev_final;
                    end
                end
                pwr_seq_pkg::dev_final: begin
                    if (done) begin
                        ref_nxt = 1'b0;
                        fin_nxt = 1'b0;
                        boot_ok_nxt = 1'b0;
                        load = 1'b1;
                        load_val = FINALIZE_CYCLES;
                        st_nxt = pwr_seq_pkg::dev_halted;
                    end
                end
                pwr_seq_pkg::dev_halted: begin
                    // fast halt with indicator waits for repower or reset
                    // otherwise a pause before reboot lets the host drop power
                    if (!pwr_s2_r) begin
                        st_nxt = pwr_seq_pkg::dev_off;
                        fast_halt_nxt = 1'b0;
                    end else if (done && !(fast_halt_r && ind_en_r)) begin
                        ref_nxt = 1'b1;
                        load = 1'b1;
                        st_nxt = pwr_seq_pkg::dev_init;
                    end
                end
                default: begin
                    st_nxt = pwr_seq_pkg::dev_off;
                end
            endcase
        end
        ind_nxt = ind_en_r && boot_ok_nxt;
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= pwr_seq_pkg::dev_off;
            ind_en_r <= `SHDN_IND_EN_RESET;
            fs_en_r <= `FAST_SHDN_EN_RESET;
            boot_ok_r <= `BOOT_OK_RESET;
            ref_r <= 1'b0;
            ind_r <= 1'b0;
            act_r <= 1'b0;
            fin_r <= 1'b0;
            fast_halt_r <= 1'b0;
            hold_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            ind_en_r <= ind_en_nxt;
            fs_en_r <= fs_en_nxt;
            boot_ok_r <= boot_ok_nxt;
            ref_r <= ref_nxt;
            ind_r <= ind_nxt;
            act_r <= act_nxt;
            fin_r <= fin_nxt;
            fast_halt_r <= fast_halt_nxt;
            hold_r <= hold_nxt;
        end
    end
    assign link.indicator_line = ind_r;
    assign link.reference_voltage_output = ref_r;
    assign active_out = act_r;
    assign finalizing_out = fin_r;
endmodule // pwr_seq_dev

// ### sim/pwr_seq_properties.sv
// concurrent checks on the link between host end and module end
`timescale 1ns/10ps
module pwr_seq_properties #(
    parameter int ACT = 50,
    parameter int HOLD = 20
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic power_on_req,
    input wire logic hard_restart_line_oe_n,
    input wire logic hard_restart_line,
    input wire logic trigger_line,
    input wire logic indicator_line,
    input wire logic reference_voltage_output
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    logic [15:0] pwr_cnt_r;
    logic [15:0] pwr_cnt_nxt;
    logic [15:0] low_cnt_r;
    logic [15:0] low_cnt_nxt;
    // run lengths of power request high and restart line low
    always_comb begin
        pwr_cnt_nxt = power_on_req ? pwr_cnt_r + 16'h0001 : 16'h0000;
        low_cnt_nxt = hard_restart_line ? 16'h0000 : low_cnt_r + 16'h0001;
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_cnt_r <= 16'h0000;
            low_cnt_r <= 16'h0000;
        end else begin
            pwr_cnt_r <= pwr_cnt_nxt;
            low_cnt_r <= low_cnt_nxt;
        end
    end
    sequence s_drain;
        reference_voltage_output [*8] ##[1:10] !reference_voltage_output;
    endsequence
    sequence s_off_level;
        !reference_voltage_output [*2];
    endsequence
    a_power_to_ref: assert property (
        $rose(power_on_req) && hard_restart_line |-> ##[1:6] reference_voltage_output)
        else $error("reference output did not follow power request");
    a_boot_not_early: assert property (
        $rose(indicator_line) |-> pwr_cnt_r >= ACT)
        else $error("boot flag raised before activation time");
    a_graceful_drain: assert property (
        $fell(power_on_req) && trigger_line && reference_voltage_output |-> s_drain)
        else $error("graceful shutdown timing wrong");
    a_flag_when_off: assert property (
        s_off_level |-> !indicator_line)
        else $error("boot flag high while module off");
    a_off_stays_off: assert property (
        !power_on_req && !reference_voltage_output |=> !reference_voltage_output)
        else $error("reference output rose without power request");
    a_restart_hold_long: assert property (
        $rose(hard_restart_line) |-> low_cnt_r > HOLD)
        else $error("restart line released too soon");
    a_lines_low_before: assert property (
        $rose(power_on_req) |-> !$past(trigger_line))
        else $error("trigger high before power request");
    a_no_power_in_reset: assert property (
        $rose(power_on_req) |-> hard_restart_line && hard_restart_line_oe_n)
        else $error("power request raised while restart line low");
    c_drain: cover property ($fell(reference_voltage_output));
endmodule // pwr_seq_properties

// ### sim/module_power_reset_sequencer_tb_top.sv
// table-driven bench of both sequencer ends joined by the link
`timescale 1ns/10ps
module module_power_reset_sequencer_tb_top;
    localparam int ACT = 50;
    localparam int HR = 20;
    localparam int FIN = 8;
    // host wait covers the module's pin synchroniser lag
    localparam int HOST_WAIT = ACT + 8;
    // fields: boot flag enable, trigger enable, use trigger, module goes off
    typedef struct packed {logic ind; logic fast; logic use_fast; logic off;} row_s;
    row_s rows [5] = '{4'h1, 4'h9, 4'hF, 4'h7, 4'h2};
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic up_req = 1'b0;
    logic down_req = 1'b0;
    logic fast_req = 1'b0;
    logic emerg_req = 1'b0;
    logic ind_en = 1'b0;
    logic fast_en = 1'b0;
    logic ready, stopped, active, finalizing;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    pwr_seq_if link ();
    pwr_seq_host #(.ACTIVATION_CYCLES(HOST_WAIT), .HARD_RESET_CYCLES(HR + 1)) u_pwr_seq_host (
        .clock_in(clock_in), .resetn_in(resetn_in), .link(link), .power_up_in(up_req),
        .power_down_in(down_req), .fast_down_in(fast_req), .emergency_reset_in(emerg_req),
        .ready_out(ready), .stopped_out(stopped));
    pwr_seq_dev #(.ACTIVATION_CYCLES(ACT), .HARD_RESET_CYCLES(HR), .FINALIZE_CYCLES(FIN))
        u_pwr_seq_dev (.clock_in(clock_in), .resetn_in(resetn_in), .link(link),
        .indicator_enable_in(ind_en), .fast_shutdown_enable_in(fast_en),
        .active_out(active), .finalizing_out(finalizing));
    pwr_seq_properties #(.ACT(ACT), .HOLD(HR)) u_pwr_seq_properties (
        .clock_in(clock_in), .resetn_in(resetn_in), .power_on_req(link.power_on_req),
        .hard_restart_line_oe_n(link.hard_restart_line_oe_n),
        .hard_restart_line(link.hard_restart_line), .trigger_line(link.trigger_line),
        .indicator_line(link.indicator_line),
        .reference_voltage_output(link.reference_voltage_output));
    always #12.5 clock_in = ~clock_in;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic check_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %b", $time, what, got);
        end
    endtask
    task automatic check_min(input int got, input int lo, input string what);
        checked++;
        if (got < lo) begin
            bad_count++;
            $display("BAD %0t %s only %0d", $time, what, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // which: 0 power up, 1 power down, 2 fast down, 3 emergency
    task automatic pulse(input int which);
        @(posedge clock_in);
        case (which)
            0: up_req <= 1'b1;
            1: down_req <= 1'b1;
            2: fast_req <= 1'b1;
            default: emerg_req <= 1'b1;
        endcase
        @(posedge clock_in);
        up_req <= 1'b0;
        down_req <= 1'b0;
        fast_req <= 1'b0;
        emerg_req <= 1'b0;
    endtask
    task automatic do_reset(input int len, input logic ie, input logic fe);
        @(posedge clock_in);
        resetn_in <= 1'b0;
        ind_en <= ie;
        fast_en <= fe;
        tick(len);
        check_bit(link.hard_restart_line_oe_n, 1'b1, "restart released");
        check_bit(link.power_on_req, 1'b0, "power low in reset");
        check_bit(link.indicator_line, 1'b0, "flag off in reset");
        check_bit(link.reference_voltage_output, 1'b0, "ref off in reset");
        @(posedge clock_in);
        resetn_in <= 1'b1;
        tick(1);
    endtask
    task automatic boot(input logic ie);
        int n;
        n = 0;
        pulse(0);
        while (ready !== 1'b1 && n < ACT + 200) begin
            tick(1);
            n++;
        end
        check_min(n, ACT, "boot wait");
        check_bit(ready, 1'b1, "ready");
        check_bit(active, 1'b1, "active");
        check_bit(link.indicator_line, ie, "boot flag");
        check_bit(link.reference_voltage_output, 1'b1, "ref on");
    endtask
    task automatic run_row(input row_s r);
        int n;
        logic saw;
        saw = 1'b0;
        n = 0;
        do_reset(4, r.ind, r.fast);
        boot(r.ind);
        if (r.use_fast) begin
            pulse(2);
        end else begin
            pulse(1);
        end
        while (stopped !== 1'b1 && n < FIN + 40) begin
            tick(1);
            saw = saw | (finalizing === 1'b1);
            n++;
        end
        check_bit(saw, r.off, "finalizing seen");
        check_bit(stopped, r.off, "stopped");
        check_bit(link.reference_voltage_output, !r.off, "ref after");
        if (r.off) begin
            check_bit(link.power_on_req, 1'b0, "power low");
        end
        $display("row %b done", r);
    endtask
    initial begin
        int n;
        do_reset(12, 1'b0, 1'b0);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        do_reset(4, 1'b1, 1'b0);
        boot(1'b1);
        pulse(3);
        n = 1;
        tick(1);
        while (link.hard_restart_line === 1'b0 && n < HR + 50) begin
            tick(1);
            n++;
        end
        check_min(n, HR + 1, "restart hold");
        tick(6);
        check_bit(active, 1'b0, "restarted");
        check_bit(link.indicator_line, 1'b0, "flag after restart");
        $display("hard restart done");
        conclude();
    end
endmodule // module_power_reset_sequencer_tb_top
